// ### verilog/ipvap_pkg.sv
// Shared constants, types and helpers of the ingress port policy block
`default_nettype none
package ipvap_pkg;
  // ----------------------------------------------------------------
  // Table geometry and register indices
  // ----------------------------------------------------------------
  localparam int          NPORT      = 24;
  localparam int          PT_W       = 109;
  localparam int          AT_W       = 78;
  localparam logic [4:0]  NPORT_5    = 5'h18;
  localparam logic [15:0] PT_BASE    = 16'hd74f;
  localparam logic [15:0] AT_BASE    = 16'hd97f;
  localparam logic [15:0] TPID_IDX   = 16'h0100;
  localparam logic [15:0] DCNT_IDX   = 16'h0101;
  localparam logic [15:0] TBL_SPAN   = 16'h0060;
  localparam logic [PT_W-1:0] PT_RST = 109'h24000000000000300001;
  localparam logic [AT_W-1:0] AT_RST = 78'h0;
  localparam logic [15:0] TPID_RST   = 16'h0000;
  localparam logic [15:0] TPID_C     = 16'h8100;
  localparam logic [15:0] TPID_S     = 16'h88a8;
  localparam logic [1:0]  COND_OFF   = 2'h3;

  // ----------------------------------------------------------------
  // Port configuration entry fields
  // ----------------------------------------------------------------
  localparam int P_LEARN   = 0;
  localparam int P_DUNK    = 1;
  localparam int P_CL3     = 2;
  localparam int P_A0EN    = 3;
  localparam int P_A0PTR   = 4;
  localparam int P_A1EN    = 7;
  localparam int P_A1PTR   = 8;
  localparam int P_OP      = 11;
  localparam int P_NEW_TAG_ID_SOURCE  = 14;
  localparam int P_DEISEL  = 16;
  localparam int P_NEW_TAG_PRIORITY_SOURCE  = 18;
  localparam int P_COND    = 20;
  localparam int P_COP     = 22;
  localparam int P_CVIDSEL = 25;
  localparam int P_CDEISEL = 27;
  localparam int P_NEW_TAG_TYPE_SOURCE = 49;
  localparam int P_DVID    = 53;
  localparam int P_DDEI    = 65;
  localparam int P_DPCP    = 66;
  localparam int P_ONMISS  = 105;
  localparam int P_ALWAYS  = 106;

  // ----------------------------------------------------------------
  // Fallback action entry fields
  // ----------------------------------------------------------------
  localparam int A_MIR   = 0;
  localparam int A_MPORT = 1;
  localparam int A_NOLRN = 6;
  localparam int A_FV    = 7;
  localparam int A_FH    = 8;
  localparam int A_CNT   = 14;
  localparam int A_CIDX  = 15;
  localparam int A_OVV   = 20;
  localparam int A_OVID  = 21;
  localparam int A_RDE   = 33;
  localparam int A_RDEV  = 34;
  localparam int A_RP    = 35;
  localparam int A_RPV   = 36;
  localparam int A_RV    = 39;
  localparam int A_RVV   = 40;
  localparam int A_RT    = 52;
  localparam int A_RTS   = 53;
  localparam int A_DROP  = 55;
  localparam int A_CPU   = 56;
  localparam int A_TP    = 57;
  localparam int A_TPORT = 58;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IPVAP_OP_NONE = 3'h0,
    IPVAP_OP_SWAP = 3'h1,
    IPVAP_OP_PUSH = 3'h2,
    IPVAP_OP_POP  = 3'h3,
    IPVAP_OP_PPOP = 3'h4
  } ipvap_op_e;

  typedef struct packed {
    logic [2:0]  pcp;
    logic        dei;
    logic [11:0] vid;
  } ipvap_tag_s;

  typedef struct packed {
    logic       valid;
    logic [4:0] src_port;
    logic [1:0] tag_cnt;
    logic       is_ip_mpls;
    logic       sa_unknown;
    logic       da_known;
    logic       learn_global;
    logic       acl_hit;
    ipvap_tag_s outer;
    ipvap_tag_s inner;
  } ipvap_pkt_s;

  typedef struct packed {
    logic       valid;
    logic       learn;
    logic       discard;
    logic       acl_drop;
    logic       to_host;
    logic       to_port;
    logic [4:0] port;
    logic       color_l3;
    logic       lk0_en;
    logic [2:0] lk0_ptr;
    logic       lk1_en;
    logic [2:0] lk1_ptr;
    ipvap_op_e  tag_op;
    ipvap_tag_s new_tag;
    logic [15:0] new_tpid;
    logic       fallback;
    logic       mirror;
    logic [4:0] mirror_port;
    logic       flow_valid;
    logic [5:0] flow;
    logic       count_en;
    logic [4:0] count_idx;
    logic [11:0] ingress_vid;
    logic       rw_dei_en;
    logic       rw_dei;
    logic       rw_pcp_en;
    logic [2:0] rw_pcp;
    logic       rw_vid_en;
    logic [11:0] rw_vid;
    logic       rw_tpid_en;
    logic [15:0] rw_tpid;
  } ipvap_dec_s;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Returns {hit, entry[4:0], word[1:0]} for a table at base
  function automatic logic [7:0] ipvap_locate(input logic [15:0] idx,
                                              input logic [15:0] base);
    logic [15:0] off;
    off = idx - base;
    ipvap_locate = {(idx >= base) && (off < TBL_SPAN), off[6:0]};
  endfunction : ipvap_locate

  function automatic logic [15:0] ipvap_tpid(input logic [1:0]  sel,
                                             input logic [15:0] usr);
    case (sel)
      2'h0:    ipvap_tpid = TPID_C;
      2'h1:    ipvap_tpid = TPID_S;
      2'h2:    ipvap_tpid = usr;
      default: ipvap_tpid = TPID_C;
    endcase
  endfunction : ipvap_tpid
endpackage : ipvap_pkg
`default_nettype wire

// ### verilog/ipvap_tag_build.sv
// Builds the new VLAN header for push and swap operations
`default_nettype none
`timescale 1ns/10ps
module ipvap_tag_build import ipvap_pkg::*; (
  // Packet tags
  input  wire logic [1:0] tag_cnt,
  input  wire ipvap_tag_s outer,
  input  wire ipvap_tag_s inner,
  input  wire ipvap_tag_s dflt,
  // Field sources
  input  wire logic [1:0] vid_sel,
  input  wire logic [1:0] dei_sel,
  input  wire logic [1:0] pcp_sel,
  // Result
  output ipvap_tag_s      new_tag
);
  // Absent headers and the unused code fall back to port defaults
  function automatic ipvap_tag_s pick(input logic [1:0] sel);
    case (sel)
      2'h0:    pick = (tag_cnt != 2'h0) ? outer : dflt;
      2'h2:    pick = (tag_cnt >= 2'h2) ? inner : dflt;
      default: pick = dflt;
    endcase
  endfunction : pick

  ipvap_tag_s t_vid;
  ipvap_tag_s t_dei;
  ipvap_tag_s t_pcp;

  always_comb begin
    t_vid       = pick(vid_sel);
    t_dei       = pick(dei_sel);
    t_pcp       = pick(pcp_sel);
    new_tag.vid = t_vid.vid;
    new_tag.dei = t_dei.dei;
    new_tag.pcp = t_pcp.pcp;
  end
endmodule : ipvap_tag_build
`default_nettype wire

// ### verilog/ipvap_top.sv
// Ingress port policy: port table, fallback actions, APB access
//
// The APB interface to the registers was left to the implementer.
`default_nettype none
`timescale 1ns/10ps
module ipvap_top import ipvap_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Packet in, decision out
  input  wire ipvap_pkt_s  pkt_in,
  output ipvap_dec_s       dec_out
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [PT_W-1:0] pt_r [NPORT];
  logic [AT_W-1:0] at_r [NPORT];
  logic [15:0]     tpid_r;
  logic [31:0]     dcnt_r;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [15:0]  idx;
  logic [7:0]   pt_loc;
  logic [7:0]   at_loc;
  logic [4:0]   pt_e;
  logic [4:0]   at_e;
  logic [127:0] pt_old;
  logic [127:0] at_old;
  logic [127:0] pt_new;
  logic [127:0] at_new;
  logic [31:0]  rd_data;
  logic         rd_err;
  logic         setup;
  logic         wr_fire;
  logic [31:0]  tpid_wr;

  assign idx     = paddr[17:2];
  assign pt_loc  = ipvap_locate(idx, PT_BASE);
  assign at_loc  = ipvap_locate(idx, AT_BASE);
  // Unmapped offsets would index past the tables, so park them on 0
  assign pt_e    = pt_loc[7] ? pt_loc[6:2] : 5'h0;
  assign at_e    = at_loc[7] ? at_loc[6:2] : 5'h0;
  assign setup   = psel & ~penable;
  assign wr_fire = psel & penable & pready & pwrite & ~pslverr;

  function automatic logic [31:0] merge(input logic [31:0] old);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = pstrb[b] ? pwdata[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction : merge

  assign tpid_wr = merge({16'h0, tpid_r});

  always_comb begin
    pt_old = {19'h0, pt_r[pt_e]};
    at_old = {50'h0, at_r[at_e]};
    pt_new = pt_old;
    at_new = at_old;
    pt_new[pt_loc[1:0]*32 +: 32] = merge(pt_old[pt_loc[1:0]*32 +: 32]);
    at_new[at_loc[1:0]*32 +: 32] = merge(at_old[at_loc[1:0]*32 +: 32]);
  end

  // Unmapped indices answer with an error; bits above a field read zero
  always_comb begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    if (pt_loc[7]) begin
      rd_data = pt_old[pt_loc[1:0]*32 +: 32];
    end else if (at_loc[7]) begin
      rd_data = at_old[at_loc[1:0]*32 +: 32];
    end else if (idx == TPID_IDX) begin
      rd_data = {16'h0, tpid_r};
    end else if (idx == DCNT_IDX) begin
      rd_data = dcnt_r;
    end else begin
      rd_err = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // APB answer: ready in the first access cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0 : rd_data;
      pslverr <= rd_err;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Table writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NPORT; i++) begin
        pt_r[i] <= PT_RST;
      end
    end else if (wr_fire && pt_loc[7]) begin
      pt_r[pt_e] <= pt_new[PT_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NPORT; i++) begin
        at_r[i] <= AT_RST;
      end
    end else if (wr_fire && at_loc[7]) begin
      at_r[at_e] <= at_new[AT_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tpid_r <= TPID_RST;
    end else if (wr_fire && !pt_loc[7] && !at_loc[7] && idx == TPID_IDX) begin
      tpid_r <= tpid_wr[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Per-packet policy
  // ----------------------------------------------------------------
  logic [PT_W-1:0] pe;
  logic [AT_W-1:0] ae;
  logic            port_ok;
  logic            cond;
  logic            looked;
  logic            apply;
  logic [2:0]      op_sel;
  logic [1:0]      vid_sel;
  logic [1:0]      dei_sel;
  ipvap_tag_s      dflt;
  ipvap_tag_s      built;
  logic            drop_now;

  assign port_ok = pkt_in.src_port < NPORT_5;
  assign pe      = pt_r[port_ok ? pkt_in.src_port : 5'h0];
  assign ae      = at_r[port_ok ? pkt_in.src_port : 5'h0];
  assign dflt    = '{pcp: pe[P_DPCP +: 3], dei: pe[P_DDEI],
                     vid: pe[P_DVID +: 12]};

  // Code 3 never matches, so the alternative set stays idle by default
  assign cond = (pe[P_COND +: 2] != COND_OFF) &&
                (pkt_in.tag_cnt == pe[P_COND +: 2]);

  assign op_sel  = cond ? pe[P_COP +: 3] : pe[P_OP +: 3];
  assign vid_sel = cond ? pe[P_CVIDSEL +: 2] : pe[P_NEW_TAG_ID_SOURCE +: 2];
  assign dei_sel = cond ? pe[P_CDEISEL +: 2] : pe[P_DEISEL +: 2];

  // A hit only counts when some lookup actually ran
  assign looked = pe[P_A0EN] | pe[P_A1EN];
  assign apply  = pe[P_ALWAYS] |
                  (pe[P_ONMISS] & ~(looked & pkt_in.acl_hit));

  assign drop_now = (pe[P_DUNK] & ~pkt_in.da_known) |
                    (apply & ae[A_DROP]);

  ipvap_tag_build u_build (
    .tag_cnt (pkt_in.tag_cnt),
    .outer   (pkt_in.outer),
    .inner   (pkt_in.inner),
    .dflt    (dflt),
    .vid_sel (vid_sel),
    .dei_sel (dei_sel),
    .pcp_sel (pe[P_NEW_TAG_PRIORITY_SOURCE +: 2]),
    .new_tag (built)
  );

  // ----------------------------------------------------------------
  // Decision register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dec_out <= '0;
    end else begin
      dec_out.valid       <= pkt_in.valid & port_ok;
      dec_out.learn       <= pkt_in.valid & port_ok & pkt_in.learn_global &
                             pe[P_LEARN] & pkt_in.sa_unknown &
                             ~(apply & ae[A_NOLRN]);
      dec_out.discard     <= drop_now;
      dec_out.acl_drop    <= pkt_in.valid & port_ok &
                             apply & ae[A_DROP];
      dec_out.to_host     <= apply & ae[A_CPU];
      dec_out.to_port     <= apply & ae[A_TP];
      dec_out.port        <= ae[A_TPORT +: 5];
      dec_out.color_l3    <= pe[P_CL3] & pkt_in.is_ip_mpls;
      dec_out.lk0_en      <= pe[P_A0EN];
      dec_out.lk0_ptr     <= pe[P_A0PTR +: 3];
      dec_out.lk1_en      <= pe[P_A1EN];
      dec_out.lk1_ptr     <= pe[P_A1PTR +: 3];
      dec_out.tag_op      <= ipvap_op_e'(op_sel);
      dec_out.new_tag     <= built;
      dec_out.new_tpid    <= ipvap_tpid(pe[P_NEW_TAG_TYPE_SOURCE +: 2],
                                        tpid_r);
      dec_out.fallback    <= apply;
      dec_out.mirror      <= apply & ae[A_MIR];
      dec_out.mirror_port <= ae[A_MPORT +: 5];
      dec_out.flow_valid  <= apply & ae[A_FV];
      dec_out.flow        <= ae[A_FH +: 6];
      dec_out.count_en    <= pkt_in.valid & port_ok &
                             apply & ae[A_CNT];
      dec_out.count_idx   <= ae[A_CIDX +: 5];
      dec_out.ingress_vid <= (apply & ae[A_OVV]) ?
                             ae[A_OVID +: 12] :
                             ((pkt_in.tag_cnt != 2'h0) ?
                              pkt_in.outer.vid : dflt.vid);
      dec_out.rw_dei_en   <= apply & ae[A_RDE];
      dec_out.rw_dei      <= ae[A_RDEV];
      dec_out.rw_pcp_en   <= apply & ae[A_RP];
      dec_out.rw_pcp      <= ae[A_RPV +: 3];
      dec_out.rw_vid_en   <= apply & ae[A_RV];
      dec_out.rw_vid      <= ae[A_RVV +: 12];
      dec_out.rw_tpid_en  <= apply & ae[A_RT];
      dec_out.rw_tpid     <= ipvap_tpid(ae[A_RTS +: 2], tpid_r);
      if (!(pkt_in.valid && port_ok)) begin
        dec_out.discard  <= 1'b0;
        dec_out.to_host  <= 1'b0;
        dec_out.to_port  <= 1'b0;
        dec_out.mirror   <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Discard statistics, readable by software
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dcnt_r <= 32'h0;
    end else if (pkt_in.valid && port_ok && drop_now) begin
      dcnt_r <= dcnt_r + 32'h1;
    end
  end
endmodule : ipvap_top
`default_nettype wire

// ### verif/ipvap_parser_model.sv
// Packet descriptor source standing in for the ingress parser
`timescale 1ns/10ps
`default_nettype none
module ipvap_parser_model import ipvap_pkg::*; (
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     reset,
  // Pacing: high leaves an idle cycle after each descriptor
  input  wire logic     slow,
  // Descriptor to the policy block
  output var ipvap_pkt_s pkt
);
  // ----------------------------------------------------------------
  // Queue and pacing
  // ----------------------------------------------------------------
  ipvap_pkt_s q[$];
  logic       gap_r;

  task automatic push(input ipvap_pkt_s d);
    q.push_back(d);
  endtask : push

  // Idle cycles show inverted fields so nothing stale looks valid
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pkt   <= '0;
      gap_r <= 1'b0;
    end else if (q.size() != 0 && !gap_r) begin
      pkt   <= q.pop_front();
      gap_r <= slow;
    end else begin
      pkt   <= {1'b0, ~pkt[$bits(ipvap_pkt_s)-2:0]};
      gap_r <= 1'b0;
    end
  end
endmodule : ipvap_parser_model
`default_nettype wire

// ### verif/ipvap_top_assertions.sv
// Checker on the policy block ports
`timescale 1ns/10ps
`default_nettype none
module ipvap_chk import ipvap_pkg::*; (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // APB
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // Packet path
  input wire ipvap_pkt_s pkt_in,
  input wire ipvap_dec_s dec_out
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && pready ##1 !pready;
  endsequence
  a_apb_answer: assert property (s_setup |=> s_answer)
    else $error("apb answer late");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_dec_latency: assert property
    (pkt_in.valid && pkt_in.src_port < NPORT_5 |=> dec_out.valid)
    else $error("decision missing");
  a_dec_cause: assert property (dec_out.valid |-> $past(pkt_in.valid))
    else $error("decision without packet");
  a_learn_cause: assert property (dec_out.learn |->
    dec_out.valid && $past(pkt_in.learn_global && pkt_in.sa_unknown))
    else $error("learn without cause");
  a_discard_cause: assert property (dec_out.discard |->
    dec_out.acl_drop || $past(!pkt_in.da_known))
    else $error("discard without cause");
  a_acl_drop: assert property (dec_out.acl_drop |->
    dec_out.fallback && dec_out.discard)
    else $error("drop not from fallback");
  a_color_l3: assert property (dec_out.valid && dec_out.color_l3 |->
    $past(pkt_in.is_ip_mpls))
    else $error("color from layer three on non ip");
  a_fallback_acts: assert property (
    dec_out.to_port || dec_out.count_en || dec_out.mirror
    |-> dec_out.valid && dec_out.fallback)
    else $error("action without fallback");
  a_ingress_vid: assert property (dec_out.valid && !dec_out.fallback
    && $past(pkt_in.tag_cnt) != 2'h0
    |-> dec_out.ingress_vid == $past(pkt_in.outer.vid))
    else $error("ingress vid not from outer tag");
endmodule : ipvap_chk
bind ipvap_top ipvap_chk u_chk (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .pkt_in(pkt_in), .dec_out(dec_out));
`default_nettype wire

// ### verif/ipvap_tb_top.sv
// Self-checking bench for the ingress port policy block
`timescale 1ns/10ps
`default_nettype none
module ipvap_tb_top import ipvap_pkg::*;;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  logic            clk, reset, psel, penable, pwrite, pready, pslverr;
  logic            slow, exp_v, er;
  logic [17:0]     paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [31:0]     rnd_s = 32'h7f83a371;
  logic [3:0]      pstrb;
  logic [127:0]    t;
  ipvap_pkt_s      pkt_in, p;
  ipvap_dec_s      dec_out, exp_d;
  logic [PT_W-1:0] pt [NPORT];
  logic [AT_W-1:0] at [NPORT];
  logic [15:0]     usr;
  int              fails, n_checks, ndisc, e;

  ipvap_top DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .pkt_in(pkt_in),
    .dec_out(dec_out));
  ipvap_parser_model par (.clk(clk), .reset(reset), .slow(slow),
    .pkt(pkt_in));

  function automatic logic [31:0] rnd();
    rnd_s = rnd_s ^ (rnd_s << 13);
    rnd_s = rnd_s ^ (rnd_s >> 17);
    rnd_s = rnd_s ^ (rnd_s << 5);
    return rnd_s;
  endfunction : rnd

  function automatic logic [15:0] tp(input logic [1:0] s);
    return s == 2'h1 ? 16'h88a8 : s == 2'h2 ? usr : 16'h8100;
  endfunction : tp

  // Missing header falls back to the port default
  function automatic ipvap_tag_s pick(input logic [1:0] s,
    input ipvap_pkt_s k, input ipvap_tag_s d);
    if (s == 2'h0 && k.tag_cnt != 2'h0) return k.outer;
    if (s == 2'h2 && k.tag_cnt >= 2'h2) return k.inner;
    return d;
  endfunction : pick

  function automatic ipvap_dec_s model(input ipvap_pkt_s k);
    logic [PT_W-1:0] x;
    logic [AT_W-1:0] a;
    logic            c, f;
    ipvap_tag_s      df, tv, td, tq;
    ipvap_dec_s      d;
    x = pt[k.src_port];
    a = at[k.src_port];
    df = {x[68:66], x[65], x[64:53]};
    c = x[21:20] != COND_OFF && k.tag_cnt == x[21:20];
    f = x[106] || x[105] && !(k.acl_hit && (x[3] || x[7]));
    tv = pick(c ? x[26:25] : x[15:14], k, df);
    td = pick(c ? x[28:27] : x[17:16], k, df);
    tq = pick(x[19:18], k, df);
    d = '0;
    d.valid = 1'b1;
    d.learn = k.learn_global && k.sa_unknown && x[0] && !(f && a[6]);
    d.acl_drop = f && a[55];
    d.discard = x[1] && !k.da_known || d.acl_drop;
    {d.to_host, d.to_port, d.port} = {f && a[56], f && a[57], a[62:58]};
    d.color_l3 = x[2] && k.is_ip_mpls;
    {d.lk1_ptr, d.lk1_en, d.lk0_ptr, d.lk0_en} = x[10:3];
    d.tag_op = ipvap_op_e'(c ? x[24:22] : x[13:11]);
    d.new_tag = {tq.pcp, td.dei, tv.vid};
    d.new_tpid = tp(x[50:49]);
    d.fallback = f;
    {d.mirror, d.mirror_port} = {f && a[0], a[5:1]};
    {d.flow_valid, d.flow} = {f && a[7], a[13:8]};
    {d.count_en, d.count_idx} = {f && a[14], a[19:15]};
    d.ingress_vid = f && a[20] ? a[32:21] :
                    k.tag_cnt != 2'h0 ? k.outer.vid : df.vid;
    {d.rw_dei_en, d.rw_dei} = {f && a[33], a[34]};
    {d.rw_pcp_en, d.rw_pcp} = {f && a[35], a[38:36]};
    {d.rw_vid_en, d.rw_vid} = {f && a[39], a[51:40]};
    {d.rw_tpid_en, d.rw_tpid} = {f && a[52], tp(a[54:53])};
    return d;
  endfunction : model

  task automatic check(input string nm, input logic [127:0] s,
                       input logic [127:0] x);
    n_checks++;
    if (s !== x) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic apb(input logic w, input logic [15:0] ix,
    input logic [31:0] d, input logic [3:0] sb);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'h0};
    pwdata <= d;
    pstrb <= sb;
    @(posedge clk);
    penable <= 1'b1;
    // Only pready high, or else the watchdog, ends the wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rdc(input logic [15:0] ix, input logic [31:0] x,
                     input logic xe);
    apb(1'b0, ix, 32'h0, 4'hf);
    check("prdata", rd, x);
    check("pslverr", er, xe);
  endtask : rdc

  // Both tables of one port, every word, against the model
  task automatic rdent(input int n);
    for (int w = 0; w < 4; w++) begin
      rdc(PT_BASE + 16'(4 * n + w), 32'(pt[n] >> (32 * w)), 1'b0);
      rdc(AT_BASE + 16'(4 * n + w), 32'(at[n] >> (32 * w)), 1'b0);
    end
  endtask : rdent

  // ----------------------------------------------------------------
  // Clock, scoreboard, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (exp_v) check("dec_out", dec_out, exp_d);
    else check("dec_valid", dec_out.valid, 1'b0);
    exp_v = !reset && pkt_in.valid && pkt_in.src_port < NPORT_5;
    if (exp_v) exp_d = model(pkt_in);
    if (exp_v && exp_d.discard) ndisc++;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, slow, exp_v} = '0;
    usr = 16'h0;
    for (int i = 0; i < NPORT; i++) pt[i] = PT_RST;
    for (int i = 0; i < NPORT; i++) at[i] = AT_RST;
    // A late rising edge makes sure every reset process sees it
    reset = 1'b0;
    #1;
    reset = 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdent(5);
    rdc(16'h0000, 32'h0, 1'b1);
    apb(1'b1, PT_BASE + 16'h0060, 32'hffffffff, 4'hf);
    check("wr_unmapped_err", er, 1'b1);
    apb(1'b1, TPID_IDX, 32'h1234abcd, 4'h1);
    rdc(TPID_IDX, 32'h000000cd, 1'b0);
    usr = 16'(rnd());
    apb(1'b1, TPID_IDX, {16'h0, usr}, 4'hf);
    // Stale counter writes must not disturb the tally
    apb(1'b1, DCNT_IDX, 32'h5, 4'hf);
    check("cnt_wr_err", er, 1'b0);
    for (int it = 0; it < 40; it++) begin
      e = int'(rnd() % NPORT);
      t = {rnd(), rnd(), rnd(), rnd()};
      pt[e] = t[PT_W-1:0];
      pt[e][13:11] = 3'(rnd() % 5);
      pt[e][24:22] = 3'(rnd() % 5);
      t = {rnd(), rnd(), rnd(), rnd()};
      at[e] = t[AT_W-1:0];
      for (int w = 0; w < 4; w++) begin
        apb(1'b1, PT_BASE + 16'(4 * e + w), 32'(pt[e] >> (32 * w)), 4'hf);
        apb(1'b1, AT_BASE + 16'(4 * e + w), 32'(at[e] >> (32 * w)), 4'hf);
      end
      rdent(e);
      slow <= (rnd() & 32'h1) != 32'h0;
      for (int k = 0; k < 12; k++) begin
        t = {rnd(), rnd(), rnd(), rnd()};
        p = ipvap_pkt_s'(t[$bits(ipvap_pkt_s)-1:0]);
        p.valid = 1'b1;
        if (rnd() & 32'h1) p.src_port = 5'(e);
        par.push(p);
      end
      while (par.q.size() != 0) @(posedge clk);
      repeat (3) @(posedge clk);
    end
    rdc(DCNT_IDX, 32'(ndisc), 1'b0);
    tally_and_finish();
  end
endmodule : ipvap_tb_top
`default_nettype wire
